// ---- src/sdt_pkg.sv ----
package sdt_pkg;

    // ------------------------------------------------------------
    // clock and speed grade (middle grade, cas latency two)
    // ------------------------------------------------------------
    localparam real CLK_NS = 8.0;            // 125 MHz controller clock
    localparam int CAS_LAT = 2;              // latency programmed at init
    localparam real TCK_CL2_MIN_NS = 8.0;    // shortest period, latency two
    localparam real TCK_CL3_MIN_NS = 6.0;    // shortest period, latency three

    // ------------------------------------------------------------
    // command timing as printed, in nanoseconds unless the name gives another unit
    // ------------------------------------------------------------
    localparam real T_RC_NS = 60.0;          // act to act, ref to ref
    localparam real T_RAS_NS = 36.0;         // act to pre, least
    localparam real T_RAS_MAX_NS = 100000.0; // act to pre, longest
    localparam real T_RP_NS = 18.0;          // pre to act
    localparam real T_RCD_NS = 18.0;         // act to read or write
    localparam real T_RRD_NS = 12.0;         // act bank a to act bank b
    localparam real CKE_EXTRA_NS = 3.0;      // clock_enable_recovery beyond one clock
    localparam real REFRESH_WINDOW_MS = 64.0;
    localparam int REFRESH_ROWS = 4096;
    localparam real POWERUP_US = 100.0;
    localparam int T_DPL_CLK = 2;            // last write data to pre
    localparam int T_DAL_CLK = 2;            // last write data to auto-pre start
    localparam int T_MCD_CLK = 2;            // mode_load_settle

    // ------------------------------------------------------------
    // conversion to whole cycles
    // ------------------------------------------------------------
    // least times round up, longest times round down, never below one
    function automatic int cyc_up(real ns);
        int c;
        c = int'($ceil(ns / CLK_NS));
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int cyc_dn(real ns);
        int c;
        c = int'($floor(ns / CLK_NS));
        return (c < 1) ? 1 : c;
    endfunction

    localparam int T_RC_CYC = cyc_up(T_RC_NS);
    localparam int T_RAS_CYC = cyc_up(T_RAS_NS);
    localparam int T_RP_CYC = cyc_up(T_RP_NS);
    localparam int T_RCD_CYC = cyc_up(T_RCD_NS);
    localparam int T_RRD_CYC = cyc_up(T_RRD_NS);
    localparam int CKE_REC_CYC = cyc_up(CLK_NS + CKE_EXTRA_NS);
    localparam int T_DAL_CYC = T_DAL_CLK + T_RP_CYC;
    localparam int REF_INT_CYC = cyc_dn(REFRESH_WINDOW_MS * 1.0e6 / REFRESH_ROWS);
    localparam int POWERUP_CYC_DEF = cyc_up(POWERUP_US * 1.0e3);
    localparam int RAS_MAX_CYC_DEF = cyc_dn(T_RAS_MAX_NS);
    localparam int INIT_REFS = 8;            // auto refreshes during init

    // ------------------------------------------------------------
    // widths, pin fields and commands {cs_n, ras_n, cas_n, we_n}
    // ------------------------------------------------------------
    localparam int CNT_W = 4;
    localparam int GAP_W = 16;
    localparam int AGE_W = 16;
    localparam int REF_W = 12;
    localparam int ROW_W = 11;
    localparam int COL_W = 8;
    localparam int ADDR_W = 12;
    localparam int DQ_W = 16;
    localparam int A10_BIT = 10;             // auto-pre / all-banks flag
    localparam int BANK_BIT = 11;            // bank select
    localparam logic [ADDR_W-1:0] MODE_WORD = 12'h020;   // burst 1, seq, cas 2
    localparam logic [ADDR_W-1:0] PRE_ALL_ADDR = 12'h400;
    localparam logic [3:0] CMD_DESEL = 4'hF;
    localparam logic [3:0] CMD_NOP = 4'h7;
    localparam logic [3:0] CMD_ACT = 4'h3;
    localparam logic [3:0] CMD_READ = 4'h5;
    localparam logic [3:0] CMD_WRITE = 4'h4;
    localparam logic [3:0] CMD_PRE = 4'h2;
    localparam logic [3:0] CMD_REF = 4'h1;
    localparam logic [3:0] CMD_MRS = 4'h0;

    typedef enum logic [3:0] {
        S_POWER, S_CKE, S_INIT_REF, S_INIT_MRS, S_IDLE, S_REF, S_ACT, S_RW, S_PRE
    } sdt_state_t;

endpackage

// ---- src/sdt_bank_if.sv ----
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------
// sequencer to per-bank timer
// ------------------------------------------------------------
interface sdt_bank_if;
    logic act;      // activate decided for this bank
    logic pre;      // precharge decided (own or all banks)
    logic rw;       // column command decided
    logic wr;       // column command is a write
    logic ap;       // column command carries auto-precharge
    logic can_act;  // bank idle and precharged
    logic can_rw;   // row open long enough for a column command
    logic can_pre;  // row open long enough to close
    logic is_open;  // row open

    modport ctrl (output act, pre, rw, wr, ap, input can_act, can_rw, can_pre, is_open);
    modport timer (input act, pre, rw, wr, ap, output can_act, can_rw, can_pre, is_open);
endinterface

`default_nettype wire

// ---- src/sdt_bank_timer.sv ----
`timescale 1ns/1ns
`default_nettype none

module sdt_bank_timer #(
    parameter int OPEN_MAX = sdt_pkg::RAS_MAX_CYC_DEF
) (
    input wire logic clock,
    input wire logic rst_n,
    sdt_bank_if.timer bi
);
    import sdt_pkg::*;

    // ------------------------------------------------------------
    // countdown state, zero means the gap has passed
    // ------------------------------------------------------------
    logic [CNT_W-1:0] rc_ff, rcd_ff, ras_ff, rp_ff, dpl_ff; // per-bank gaps
    logic open_ff; // row open
    logic [AGE_W-1:0] age_ff; // cycles the row has stayed open
    logic ap_close; // column command closes the row itself

    // load a gap on its event, else count down to zero
    function automatic logic [CNT_W-1:0] step(logic ld, int val, logic [CNT_W-1:0] cur);
        if (ld) begin
            return CNT_W'(val - 1);
        end
        return (cur != '0) ? cur - 1'b1 : cur;
    endfunction

    assign ap_close = bi.rw && bi.ap;

    // ------------------------------------------------------------
    // counters
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rc_ff <= '0;
            rcd_ff <= '0;
            ras_ff <= '0;
            rp_ff <= '0;
            dpl_ff <= '0;
            open_ff <= 1'b0;
            age_ff <= '0;
        end else begin
            rc_ff <= step(bi.act, T_RC_CYC, rc_ff);
            ras_ff <= step(bi.act, T_RAS_CYC, ras_ff);
            rcd_ff <= step(bi.act, T_RCD_CYC, rcd_ff);
            dpl_ff <= step(bi.rw && bi.wr && !bi.ap, T_DPL_CLK, dpl_ff);
            // auto-pre reads are treated like writes: costs little, never early
            rp_ff <= ap_close ? CNT_W'(T_DAL_CYC - 1) : step(bi.pre, T_RP_CYC, rp_ff);
            open_ff <= bi.act | (open_ff & ~bi.pre & ~ap_close);
            age_ff <= bi.act ? '0 : (open_ff ? age_ff + 1'b1 : '0);
        end
    end

    assign bi.is_open = open_ff;
    assign bi.can_act = !open_ff && rc_ff == '0 && rp_ff == '0;
    assign bi.can_rw = open_ff && rcd_ff == '0;
    assign bi.can_pre = open_ff && ras_ff == '0 && dpl_ff == '0;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_open_bound: assert property (@(posedge clock) disable iff (!rst_n)
        open_ff |-> age_ff < AGE_W'(OPEN_MAX))
        else $error("row held open beyond the longest active time");

endmodule

`default_nettype wire

// ---- src/sdt_ctrl.sv ----
// How it works
// - same-bank activates and refreshes spaced row cycle
// - activate to precharge: least and longest bound
// - precharge to activate waits precharge time
// - activate to read or write waits
// - activates to different banks spaced apart
// - two clocks after write data before precharge
// - auto-precharge write: two clocks plus precharge
// - one refresh every window over row count
// - hundred microsecond wait, then init sequence
// - clock period meets latency minimum
// - clock enable raised: one clock plus three
// - address ten high precharges both banks
// - next command two clocks after mode load
// - refresh only with both banks precharged
`timescale 1ns/1ns
`default_nettype none

module sdt_ctrl #(
    parameter int POWERUP_CYC = sdt_pkg::POWERUP_CYC_DEF,
    parameter int RAS_MAX_CYC = sdt_pkg::RAS_MAX_CYC_DEF
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic req_auto_pre,
    input wire logic req_bank,
    input wire logic [sdt_pkg::ROW_W-1:0] req_row,
    input wire logic [sdt_pkg::COL_W-1:0] req_col,
    input wire logic [sdt_pkg::DQ_W-1:0] req_wdata,
    output logic rd_valid,
    output logic [sdt_pkg::DQ_W-1:0] rd_data,
    output logic init_done,
    output logic sd_cke,
    output logic sd_cs_n,
    output logic sd_ras_n,
    output logic sd_cas_n,
    output logic sd_we_n,
    output logic [sdt_pkg::ADDR_W-1:0] sd_addr,
    output logic [1:0] sd_dqm,
    output logic [sdt_pkg::DQ_W-1:0] sd_dq_out,
    output logic sd_dq_oe,
    input wire logic [sdt_pkg::DQ_W-1:0] sd_dq_in
);
    import sdt_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    sdt_state_t state_ff, nxt_state; // sequencer
    logic [GAP_W-1:0] gap_ff, nxt_gap; // global command gap
    logic [CNT_W-1:0] rrd_ff; // bank-to-bank activate gap
    logic [3:0] refs_ff; // init refreshes done
    logic [REF_W-1:0] ref_cnt_ff; // refresh interval divider
    logic ref_due_ff; // a refresh is owed
    logic ready_ff, init_ff, nxt_init; // user handshake, init finished
    logic bank_ff, wr_ff, ap_ff; // latched request
    logic [ROW_W-1:0] row_ff;
    logic [COL_W-1:0] col_ff;
    logic [DQ_W-1:0] wdata_ff;
    logic cke_ff, nxt_cke; // pin registers
    logic [3:0] cmd_ff, nxt_cmd;
    logic [ADDR_W-1:0] addr_ff, nxt_addr;
    logic [1:0] dqm_ff;
    logic [DQ_W-1:0] dq_out_ff;
    logic dq_oe_ff, nxt_oe;
    logic [CAS_LAT:0] rd_pipe_ff; // read return tracking
    logic rd_valid_ff;
    logic [DQ_W-1:0] rd_data_ff;

    // ------------------------------------------------------------
    // decoding
    // ------------------------------------------------------------
    logic take, gap_ok, ref_tick, ref_clr, go_act, go_rw, go_pre, go_pre_all;
    logic [1:0] can_act_w, can_rw_w, can_pre_w, open_w;
    wire logic p_act, p_rw, p_wr, p_pre, p_ref, p_mrs, p_a10, p_bank;

    assign take = ready_ff && req_valid;
    assign gap_ok = gap_ff == '0;
    assign ref_tick = ref_cnt_ff == '0;
    // pin view of the command being presented to the memory
    assign p_act = cmd_ff == CMD_ACT;
    assign p_wr = cmd_ff == CMD_WRITE;
    assign p_rw = p_wr || cmd_ff == CMD_READ;
    assign p_pre = cmd_ff == CMD_PRE;
    assign p_ref = cmd_ff == CMD_REF;
    assign p_mrs = cmd_ff == CMD_MRS;
    assign p_a10 = addr_ff[A10_BIT];
    assign p_bank = addr_ff[BANK_BIT];

    // ------------------------------------------------------------
    // per-bank timers
    // ------------------------------------------------------------
    for (genvar b = 0; b < 2; b++) begin : g_bank
        sdt_bank_if bif();
        sdt_bank_timer #(.OPEN_MAX(RAS_MAX_CYC)) u_timer (
            .clock(clock),
            .rst_n(rst_n),
            .bi(bif)
        );
        assign bif.act = go_act && bank_ff == 1'(b);
        // an all-banks precharge reaches both timers
        assign bif.pre = go_pre_all || (go_pre && bank_ff == 1'(b));
        assign bif.rw = go_rw && bank_ff == 1'(b);
        assign bif.wr = wr_ff;
        assign bif.ap = ap_ff;
        assign can_act_w[b] = bif.can_act;
        assign can_rw_w[b] = bif.can_rw;
        assign can_pre_w[b] = bif.can_pre;
        assign open_w[b] = bif.is_open;
    end

    // ------------------------------------------------------------
    // sequencer: one command decision per cycle, registered to pins
    // ------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_gap = gap_ok ? gap_ff : gap_ff - 1'b1;
        nxt_cmd = (state_ff == S_POWER) ? CMD_DESEL : CMD_NOP;
        nxt_addr = '0;
        nxt_cke = cke_ff;
        nxt_oe = 1'b0;
        nxt_init = init_ff;
        go_act = 1'b0;
        go_rw = 1'b0;
        go_pre = 1'b0;
        go_pre_all = 1'b0;
        ref_clr = 1'b0;
        case (state_ff)
            S_POWER: begin
                // clock enable held low through the supply settle wait
                if (gap_ok) begin
                    nxt_cke = 1'b1;
                    nxt_gap = GAP_W'(CKE_REC_CYC);
                    nxt_state = S_CKE;
                end
            end
            S_CKE: begin
                // gap counts from the pin edge, hence the full recovery count
                if (gap_ok) begin
                    nxt_cmd = CMD_PRE;
                    nxt_addr = PRE_ALL_ADDR;
                    go_pre_all = 1'b1;
                    nxt_gap = GAP_W'(T_RP_CYC - 1);
                    nxt_state = S_INIT_REF;
                end
            end
            S_INIT_REF: begin
                if (gap_ok) begin
                    nxt_cmd = CMD_REF;
                    nxt_gap = GAP_W'(T_RC_CYC - 1);
                    if (refs_ff == 4'(INIT_REFS - 1)) begin
                        nxt_state = S_INIT_MRS;
                    end
                end
            end
            S_INIT_MRS: begin
                if (gap_ok) begin
                    nxt_cmd = CMD_MRS;
                    nxt_addr = MODE_WORD;
                    nxt_gap = GAP_W'(T_MCD_CLK - 1);
                    nxt_init = 1'b1;
                    nxt_state = S_IDLE;
                end
            end
            S_IDLE: begin
                // refresh outranks a waiting request
                if (ref_due_ff) begin
                    nxt_state = S_REF;
                end else if (take) begin
                    nxt_state = S_ACT;
                end
            end
            S_REF: begin
                if (gap_ok && &can_act_w) begin
                    nxt_cmd = CMD_REF;
                    nxt_gap = GAP_W'(T_RC_CYC - 1);
                    ref_clr = 1'b1;
                    nxt_state = S_IDLE;
                end
            end
            S_ACT: begin
                if (gap_ok && can_act_w[bank_ff] && rrd_ff == '0) begin
                    nxt_cmd = CMD_ACT;
                    nxt_addr = {bank_ff, row_ff};
                    go_act = 1'b1;
                    nxt_state = S_RW;
                end
            end
            S_RW: begin
                if (can_rw_w[bank_ff]) begin
                    nxt_cmd = wr_ff ? CMD_WRITE : CMD_READ;
                    nxt_addr = {bank_ff, ap_ff, 2'h0, col_ff};
                    nxt_oe = wr_ff;
                    go_rw = 1'b1;
                    nxt_state = ap_ff ? S_IDLE : S_PRE;
                end
            end
            S_PRE: begin
                if (can_pre_w[bank_ff]) begin
                    nxt_cmd = CMD_PRE;
                    nxt_addr = {bank_ff, 11'h000};
                    go_pre = 1'b1;
                    nxt_state = S_IDLE;
                end
            end
            default: begin
                nxt_state = S_POWER;
            end
        endcase
    end

    // ------------------------------------------------------------
    // sequencer registers
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_ff <= S_POWER;
            gap_ff <= GAP_W'(POWERUP_CYC - 1);
            rrd_ff <= '0;
            refs_ff <= '0;
            init_ff <= 1'b0;
            ready_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            gap_ff <= nxt_gap;
            rrd_ff <= go_act ? CNT_W'(T_RRD_CYC - 1) : (rrd_ff != '0 ? rrd_ff - 1'b1 : rrd_ff);
            refs_ff <= refs_ff + 4'((state_ff == S_INIT_REF) && gap_ok);
            init_ff <= nxt_init;
            ready_ff <= nxt_state == S_IDLE && !ref_due_ff && !ref_tick;
        end
    end

    // request latch; no reset needed, only read after a take
    always_ff @(posedge clock) begin
        if (take) begin
            bank_ff <= req_bank;
            wr_ff <= req_write;
            ap_ff <= req_auto_pre;
            row_ff <= req_row;
            col_ff <= req_col;
            wdata_ff <= req_wdata;
        end
    end

    // ------------------------------------------------------------
    // refresh budget
    // ------------------------------------------------------------
    // a tick in the clearing cycle keeps the flag set
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ref_cnt_ff <= REF_W'(REF_INT_CYC - 1);
            ref_due_ff <= 1'b0;
        end else begin
            ref_cnt_ff <= ref_tick ? REF_W'(REF_INT_CYC - 1) : ref_cnt_ff - 1'b1;
            ref_due_ff <= ref_tick | (ref_due_ff & ~ref_clr);
        end
    end

    // ------------------------------------------------------------
    // pins and read return
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cke_ff <= 1'b0;
            cmd_ff <= CMD_DESEL;
            addr_ff <= '0;
            dqm_ff <= 2'h3;
            dq_out_ff <= '0;
            dq_oe_ff <= 1'b0;
            rd_pipe_ff <= '0;
            rd_valid_ff <= 1'b0;
            rd_data_ff <= '0;
        end else begin
            cke_ff <= nxt_cke;
            cmd_ff <= nxt_cmd;
            addr_ff <= nxt_addr;
            dqm_ff <= {2{~nxt_init}}; // masked until the mode is loaded
            dq_out_ff <= nxt_oe ? wdata_ff : '0;
            dq_oe_ff <= nxt_oe;
            rd_pipe_ff <= {rd_pipe_ff[CAS_LAT-1:0], go_rw && !wr_ff};
            rd_valid_ff <= rd_pipe_ff[CAS_LAT];
            rd_data_ff <= rd_pipe_ff[CAS_LAT] ? sd_dq_in : rd_data_ff;
        end
    end

    assign req_ready = ready_ff;
    assign init_done = init_ff;
    assign rd_valid = rd_valid_ff;
    assign rd_data = rd_data_ff;
    assign sd_cke = cke_ff;
    assign {sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n} = cmd_ff;
    assign sd_addr = addr_ff;
    assign sd_dqm = dqm_ff;
    assign sd_dq_out = dq_out_ff;
    assign sd_dq_oe = dq_oe_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    // shortest legal period follows the latency programmed at init; kept integral for the checker
    localparam bit PERIOD_OK = (CAS_LAT == 3) ? (CLK_NS >= TCK_CL3_MIN_NS) : (CLK_NS >= TCK_CL2_MIN_NS);

    chk_clk_period: assert property (PERIOD_OK)
        else $error("clock too fast for the programmed latency");
    chk_rc_same_bank: assert property ((p_act && !p_bank) |=> !(p_act && !p_bank)[*7])
        else $error("activate to activate too close");
    chk_ref_gap: assert property (p_ref |=> (!p_ref && !p_act)[*7])
        else $error("refresh followed too soon");
    chk_ras_min: assert property ((p_act && !p_bank) |=> !(p_pre && (p_a10 || !p_bank))[*4])
        else $error("precharge too soon after activate");
    chk_rp_min: assert property ((p_pre && (p_a10 || !p_bank)) |=> !((p_act && !p_bank) || p_ref)[*2])
        else $error("activate too soon after precharge");
    chk_rcd_min: assert property ((p_act && !p_bank) |=> !(p_rw && !p_bank)[*2])
        else $error("column command too soon after activate");
    chk_rrd_min: assert property (p_act |=> !p_act)
        else $error("activates too close together");
    chk_dpl_min: assert property ((p_wr && !p_a10) |=> !p_pre)
        else $error("precharge too soon after write data");
    chk_dal_min: assert property ((p_wr && p_a10 && !p_bank) |=> !((p_act && !p_bank) || p_ref)[*4])
        else $error("activate too soon after auto-precharge write");
    chk_ref_served: assert property ($rose(ref_due_ff) |-> ##[1:64] p_ref)
        else $error("owed refresh not issued in time");
    chk_power_first: assert property (!init_ff |-> !(p_act || p_rw))
        else $error("access before initialisation");
    chk_cke_recover: assert property ($rose(cke_ff) |=> cmd_ff == CMD_NOP)
        else $error("command too soon after clock enable");
    chk_pre_all: assert property ((state_ff == S_CKE && gap_ok) |=> p_pre && p_a10)
        else $error("init precharge does not close both banks");
    chk_mrs_settle: assert property (p_mrs |=> cmd_ff == CMD_NOP)
        else $error("command too soon after mode load");
    chk_ref_idle: assert property (p_ref |-> (&can_act_w && !(|open_w)))
        else $error("refresh with a bank open");

    cov_read: cover property (rd_valid_ff);
    cov_write_ap: cover property (p_wr && p_a10);
    cov_refresh_run: cover property (init_ff && p_ref);
    cov_init: cover property ($rose(init_ff));

endmodule

`default_nettype wire

// ---- verification/sdt_mem_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// ------------------------------
// memory device partner
// ------------------------------
module sdt_mem_model
    import sdt_pkg::*;
(
    input wire logic clock,
    input wire logic cke,
    input wire logic [3:0] cmd,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DQ_W-1:0] dq_w,
    output logic [DQ_W-1:0] dq_r,
    output int viol
);
    logic [DQ_W-1:0] mem [0:8191]; // bank, row nibble, column
    logic [DQ_W-1:0] d1 = '0, d2 = '0; // latency stages
    logic v1 = 0, v2 = 0, ck = 0, b;
    logic [3:0] row [2];
    logic opn [2] = '{0, 0}, ap [2] = '{0, 0};
    int now = 0, mt = -99, kt = -99, rt = 0, at [2] = '{-99, -99}, pt [2] = '{-99, -99}, wt [2] = '{-99, -99};
    assign b = addr[BANK_BIT];
    // idle bus shows the inverse of the last word, never a stale copy
    assign dq_r = v2 ? d2 : ~d2;
    initial viol = 0;
    // command decode and spacing checks, one command per edge
    always @(posedge clock) begin
        now++;
        v1 <= (cmd == CMD_READ);
        v2 <= v1;
        if (v1) d2 <= d1;
        if (cke && !ck) kt = now;
        ck = cke;
        if (mt > 0 && now - rt > REF_INT_CYC + 32) viol++;
        if (cmd[3] == 1'b0 && cmd != CMD_NOP) begin
            if (now - mt < T_MCD_CLK || now - kt < CKE_REC_CYC) viol++;
            if (cmd == CMD_ACT) begin
                if (opn[b] || now - at[b] < T_RC_CYC || now - pt[b] < T_RP_CYC) viol++;
                if (now - at[!b] < T_RRD_CYC || (ap[b] && now - wt[b] < T_DAL_CYC)) viol++;
                at[b] = now; opn[b] = 1; ap[b] = 0; row[b] = addr[3:0];
            end
            if (cmd == CMD_READ || cmd == CMD_WRITE) begin
                if (!opn[b] || now - at[b] < T_RCD_CYC) viol++;
                if (cmd == CMD_WRITE) begin
                    mem[{b, row[b], addr[7:0]}] = dq_w; wt[b] = now; ap[b] = addr[A10_BIT];
                end else d1 <= mem[{b, row[b], addr[7:0]}];
                if (addr[A10_BIT]) opn[b] = 0;
            end
            for (int k = 0; k < 2; k++) if (cmd == CMD_PRE && (addr[A10_BIT] || b == k)) begin
                if ((opn[k] && now - at[k] < T_RAS_CYC) || now - wt[k] < T_DPL_CLK) viol++;
                opn[k] = 0; pt[k] = now;
            end
            if (cmd == CMD_REF) begin
                if (opn[0] || opn[1] || now - rt < T_RC_CYC) viol++;
                rt = now;
            end
            if (cmd == CMD_MRS) mt = now;
        end
    end
endmodule
`default_nettype wire

// ---- verification/sdram_command_timing_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
module sdram_command_timing_bench;
    import sdt_pkg::*;
    localparam int POW = 20; // shortened power-up wait
    logic clock = 0, rst_n = 0, req_valid = 0, req_write = 0, req_auto_pre = 0, req_bank = 0;
    logic [ROW_W-1:0] req_row = '0, r;
    logic [COL_W-1:0] req_col = '0;
    logic [DQ_W-1:0] req_wdata = '0, rd_data, sd_dq_out, sd_dq_in, d;
    logic [ADDR_W-1:0] sd_addr;
    logic [1:0] sd_dqm;
    logic req_ready, rd_valid, init_done, sd_cke, sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n, sd_dq_oe, b;
    int bad_count = 0, total_checks = 0, seed = 18, viol, n;
    always #4 clock = ~clock;
    sdt_ctrl #(.POWERUP_CYC(POW), .RAS_MAX_CYC(16)) i_dut (.clock(clock), .rst_n(rst_n),
        .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write), .req_auto_pre(req_auto_pre),
        .req_bank(req_bank), .req_row(req_row), .req_col(req_col), .req_wdata(req_wdata),
        .rd_valid(rd_valid), .rd_data(rd_data), .init_done(init_done), .sd_cke(sd_cke), .sd_cs_n(sd_cs_n),
        .sd_ras_n(sd_ras_n), .sd_cas_n(sd_cas_n), .sd_we_n(sd_we_n), .sd_addr(sd_addr), .sd_dqm(sd_dqm),
        .sd_dq_out(sd_dq_out), .sd_dq_oe(sd_dq_oe), .sd_dq_in(sd_dq_in));
    sdt_mem_model i_mem (.clock(clock), .cke(sd_cke), .cmd({sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n}),
        .addr(sd_addr), .dq_w(sd_dq_out), .dq_r(sd_dq_in), .viol(viol));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // one request held until taken; a read waits for its word
    task automatic req(input logic w, input logic bk, input logic [ROW_W-1:0] rw, input logic [COL_W-1:0] c,
                       input logic [DQ_W-1:0] dw);
        int k;
        @(posedge clock);
        {req_valid, req_write, req_bank, req_row, req_col, req_wdata} <= {1'b1, w, bk, rw, c, dw};
        req_auto_pre <= $random(seed);
        k = 0;
        do begin @(negedge clock); k++; end while (req_ready !== 1'b1 && k < 3000);
        @(posedge clock);
        req_valid <= 1'b0;
        k = 0;
        if (!w) do begin @(negedge clock); k++; end while (rd_valid !== 1'b1 && k < 40);
        if (!w) check("rd_valid", rd_valid, 1'b1);
        if (!w) check("rd_data", rd_data, dw);
    endtask
    // hang guard, several times the expected few thousand cycles
    initial begin
        #160000;
        bad_count++;
        finish_test;
    end
    initial begin
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        repeat (POW - 2) begin
            @(negedge clock);
            check("cke_low", sd_cke, 1'b0);
            check("desel", sd_cs_n, 1'b1);
            check("dqm_masked", sd_dqm, 2'h3);
        end
        n = 0;
        while (init_done !== 1'b1 && n < 500) begin @(negedge clock); n++; end
        check("init_done", init_done, 1'b1);
        check("dqm_open", sd_dqm, 2'h0);
        for (int i = 0; i < 60; i++) begin
            b = $random(seed);
            d = $random(seed);
            // one row per pass, so each read finds the word its bank was given; top row first
            r = (i == 0) ? 11'h7FF : 11'({$random(seed)} % 16);
            req(1'b1, b, r, 8'hFF, d);
            req(1'b1, !b, r, 8'h00, ~d);
            req(1'b0, b, r, 8'hFF, d);
            req(1'b0, !b, r, 8'h00, ~d);
        end
        check("violations", viol, 0);
        finish_test;
    end
endmodule
`default_nettype wire
